// *** core/asg_pkg.sv ***
package asg_pkg;

  // ************************************************************
  // Transfer modes
  // ************************************************************
  typedef enum logic [1:0] {
    ASG_MODE_PIO   = 2'h0,
    ASG_MODE_MWDMA = 2'h1,
    ASG_MODE_UDMA  = 2'h2
  } asg_mode_t;

  // ************************************************************
  // Firmware timing settings
  // ************************************************************
  typedef struct packed {
    asg_mode_t  mode;
    logic [7:0] assertCnt;
    logic [7:0] recoverCnt;
  } asg_timing_t;

  // ************************************************************
  // Phase lengths: cycles = setting + extra; load = setting + extra - 1
  // ************************************************************
  localparam int unsigned ASG_PIO_ASSERT_EXTRA = 1;
  localparam int unsigned ASG_PIO_RECOVER_EXTRA = 2;
  localparam int unsigned ASG_UDMA_ASSERT_EXTRA = 2;
  localparam int unsigned ASG_UDMA_RECOVER_EXTRA = 1;
  localparam logic [8:0] ASG_PIO_ASSERT_OFS =
    9'(ASG_PIO_ASSERT_EXTRA - 1);
  localparam logic [8:0] ASG_PIO_RECOVER_OFS =
    9'(ASG_PIO_RECOVER_EXTRA - 1);
  localparam logic [8:0] ASG_UDMA_ASSERT_OFS =
    9'(ASG_UDMA_ASSERT_EXTRA - 1);
  localparam logic [8:0] ASG_UDMA_RECOVER_OFS =
    9'(ASG_UDMA_RECOVER_EXTRA - 1);

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [8:0] ASG_CNT_RESET = 9'h000;
  localparam logic [8:0] ASG_LEN_RESET = 9'h000;

endpackage

// *** core/asg_phase_counter.sv ***
`timescale 1ns/1ps
module asg_phase_counter
  import asg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [8:0] loadVal,
  output logic [8:0] count,
  output logic expired
);

  // ************************************************************
  // Down counter, one step per clock
  // ************************************************************
  logic [8:0] count_reg;
  logic [8:0] count_next;

  assign count_next = load ? loadVal :
                      (count_reg != 9'h000) ? count_reg - 9'h001 :
                      9'h000;
  assign count = count_reg;
  assign expired = (count_reg == 9'h000);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= ASG_CNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // asg_phase_counter

// *** core/ata_strobe_timing_generator.sv ***
`timescale 1ns/1ps
// Functional notes
// [RQ1] All phases are counted in whole cycles of the single core clock.
// [RQ2] PIO/MWDMA strobe stays asserted for assertion setting plus one.
// [RQ3] PIO/MWDMA recovery lasts recovery setting plus two cycles.
// [RQ4] Firmware uses 17/16 for PIO mode 0.
// [RQ5] Firmware uses MWDMA 12/14, 4/2, 4/1; mode 0 values otherwise.
// [RQ6] Ultra DMA assertion phase is setting plus two cycles.
// [RQ7] Ultra DMA recovery is at least setting plus one cycle.
// [RQ8] Ultra DMA recovery applies only on pause, never while streaming; the code also enters recovery whenever wordReq is low.
// [RQ9] Ultra DMA strobe toggles once per assertion interval.
// [RQ10] Firmware Ultra DMA write settings 5/9, 3/7, 2/5, 1/5.
// [RQ11] Firmware may query drive modes before programming counts.
// [RQ12] Each word: assertion count strobe high, then recovery strobe low. Ultra DMA words instead end on each strobe toggle, with no recovery.
module ata_strobe_timing_generator
  import asg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input asg_timing_t timing,
  input wire logic wordReq,
  input wire logic pausePin,
  output logic strobe,
  output logic wordDone,
  output logic busy
);

  // ************************************************************
  // Reset and pin synchronisers
  // ************************************************************
  logic rstMeta_reg;
  logic rstSync_reg;
  logic pauseMeta_reg;
  logic pauseSync_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      pauseMeta_reg <= 1'b0;
      pauseSync_reg <= 1'b0;
    end else begin
      pauseMeta_reg <= pausePin;
      pauseSync_reg <= pauseMeta_reg;
    end
  end

  // ************************************************************
  // State machine declarations
  // ************************************************************
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_ASSERT  = 5'h02,
    ST_RECOVER = 5'h04,
    ST_URUN    = 5'h08,
    ST_UPAUSE  = 5'h10
  } asg_state_t;

  asg_state_t state_reg;
  asg_state_t state_next;
  logic strobe_reg;
  logic strobe_next;
  logic wordDone_reg;
  logic wordDone_next;
  logic busy_reg;
  logic cntLoad;
  logic [8:0] cntLoadVal;
  logic [8:0] cntVal;
  logic cntExpired;

  // ************************************************************
  // Phase length decode
  // ************************************************************
  wire isUdma = (timing.mode == ASG_MODE_UDMA);
  wire udmaHold = pauseSync_reg | ~wordReq;
  wire [8:0] pioAssertLoad = {1'b0, timing.assertCnt} +
    ASG_PIO_ASSERT_OFS; // [RQ2]
  wire [8:0] pioRecoverLoad = {1'b0, timing.recoverCnt} +
    ASG_PIO_RECOVER_OFS; // [RQ3]
  wire [8:0] udmaAssertLoad = {1'b0, timing.assertCnt} +
    ASG_UDMA_ASSERT_OFS; // [RQ6]
  wire [8:0] udmaRecoverLoad = {1'b0, timing.recoverCnt} +
    ASG_UDMA_RECOVER_OFS; // [RQ7]

  asg_phase_counter u_phase_counter (
    .core_clk(core_clk),
    .rst_n(rstSync_reg),
    .load(cntLoad),
    .loadVal(cntLoadVal),
    .count(cntVal),
    .expired(cntExpired)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    strobe_next = strobe_reg;
    wordDone_next = 1'b0;
    cntLoad = 1'b0;
    cntLoadVal = pioAssertLoad;
    case (state_reg)
      ST_IDLE: begin
        if (wordReq && isUdma) begin
          state_next = ST_URUN;
          cntLoad = 1'b1;
          cntLoadVal = udmaAssertLoad;
        end else if (wordReq) begin
          state_next = ST_ASSERT; // [RQ12]
          strobe_next = 1'b1;
          cntLoad = 1'b1;
          cntLoadVal = pioAssertLoad;
        end
      end
      ST_ASSERT: begin
        if (cntExpired) begin
          state_next = ST_RECOVER; // [RQ12]
          strobe_next = 1'b0;
          cntLoad = 1'b1;
          cntLoadVal = pioRecoverLoad;
        end
      end
      ST_RECOVER: begin
        if (cntExpired) begin
          wordDone_next = 1'b1;
          if (wordReq && !isUdma) begin
            state_next = ST_ASSERT; // [RQ12]
            strobe_next = 1'b1;
            cntLoad = 1'b1;
            cntLoadVal = pioAssertLoad;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_URUN: begin
        if (udmaHold) begin
          state_next = ST_UPAUSE; // [RQ8]
          cntLoad = 1'b1;
          cntLoadVal = udmaRecoverLoad;
        end else if (cntExpired) begin
          strobe_next = ~strobe_reg; // [RQ9]
          wordDone_next = 1'b1;
          cntLoad = 1'b1;
          cntLoadVal = udmaAssertLoad;
        end
      end
      ST_UPAUSE: begin
        if (!isUdma) begin
          state_next = ST_IDLE;
          strobe_next = 1'b0;
        end else if (udmaHold) begin
          cntLoad = 1'b1;
          cntLoadVal = udmaRecoverLoad; // [RQ7]
        end else if (cntExpired) begin
          state_next = ST_URUN;
          cntLoad = 1'b1;
          cntLoadVal = udmaAssertLoad;
        end
      end
      default: begin
        state_next = ST_IDLE;
        strobe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      state_reg <= ST_IDLE;
      strobe_reg <= 1'b0;
      wordDone_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      strobe_reg <= strobe_next;
      wordDone_reg <= wordDone_next;
      busy_reg <= (state_next != ST_IDLE);
    end
  end

  assign strobe = strobe_reg;
  assign wordDone = wordDone_reg;
  assign busy = busy_reg;

  // ************************************************************
  // Checking helpers
  // ************************************************************
  logic [8:0] runLen_reg;
  logic [8:0] urunLen_reg;
  logic [8:0] pauseLen_reg;
  wire strobeToggle = (strobe_next != strobe_reg);
  wire urunToggle = (state_reg == ST_URUN) && !udmaHold && cntExpired;

  always_ff @(posedge core_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      runLen_reg <= ASG_LEN_RESET;
      urunLen_reg <= ASG_LEN_RESET;
      pauseLen_reg <= ASG_LEN_RESET;
    end else begin
      runLen_reg <= strobeToggle ? 9'h001 :
                    (runLen_reg == 9'h1FF) ? runLen_reg :
                    runLen_reg + 9'h001;
      urunLen_reg <= ((state_reg == ST_URUN) && !urunToggle) ?
                     urunLen_reg + 9'h001 : 9'h000;
      pauseLen_reg <= ((state_reg == ST_UPAUSE) && !udmaHold) ?
                      pauseLen_reg + 9'h001 : 9'h000;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_one_step;
    @(posedge core_clk) disable iff (!rstSync_reg)
      (!cntLoad && !cntExpired) |=> (cntVal == $past(cntVal) - 9'h001);
  endproperty
  a_one_step: assert property (p_one_step) // [RQ1]
    else $error("Phase counter did not step by one");

  property p_pio_assert;
    @(posedge core_clk) disable iff (!rstSync_reg)
      ($fell(strobe_reg) && $past(state_reg) == ST_ASSERT) |->
        ($past(runLen_reg) == {1'b0, timing.assertCnt} + 9'h001);
  endproperty
  a_pio_assert: assert property (p_pio_assert) // [RQ2]
    else $error("PIO assertion length wrong");

  property p_pio_recover;
    @(posedge core_clk) disable iff (!rstSync_reg)
      ($rose(strobe_reg) && $past(state_reg) == ST_RECOVER) |->
        ($past(runLen_reg) == {1'b0, timing.recoverCnt} + 9'h002);
  endproperty
  a_pio_recover: assert property (p_pio_recover) // [RQ3]
    else $error("PIO recovery length wrong");

  property p_udma_assert;
    @(posedge core_clk) disable iff (!rstSync_reg)
      ($changed(strobe_reg) && $past(state_reg) == ST_URUN) |->
        ($past(runLen_reg) >= {1'b0, timing.assertCnt} + 9'h002);
  endproperty
  a_udma_assert: assert property (p_udma_assert) // [RQ6]
    else $error("Ultra DMA assertion too short");

  property p_udma_cycle;
    @(posedge core_clk) disable iff (!rstSync_reg)
      ($changed(strobe_reg) && $past(state_reg) == ST_URUN) |->
        ($past(urunLen_reg) == {1'b0, timing.assertCnt} + 9'h001);
  endproperty
  a_udma_cycle: assert property (p_udma_cycle) // [RQ9]
    else $error("Ultra DMA toggle interval wrong");

  property p_udma_recover;
    @(posedge core_clk) disable iff (!rstSync_reg)
      (state_reg == ST_URUN && $past(state_reg) == ST_UPAUSE) |->
        ($past(pauseLen_reg) >= {1'b0, timing.recoverCnt});
  endproperty
  a_udma_recover: assert property (p_udma_recover) // [RQ7]
    else $error("Ultra DMA recovery too short");

  property p_udma_stream;
    @(posedge core_clk) disable iff (!rstSync_reg)
      (state_reg == ST_URUN && !udmaHold) |=> (state_reg == ST_URUN);
  endproperty
  a_udma_stream: assert property (p_udma_stream) // [RQ8]
    else $error("Recovery inserted while streaming");

  property p_word_order;
    @(posedge core_clk) disable iff (!rstSync_reg)
      (wordDone_reg && !isUdma) |-> ($past(state_reg) == ST_RECOVER);
  endproperty
  a_word_order: assert property (p_word_order) // [RQ12]
    else $error("Word finished outside recovery");

  c_pio_word: cover property (@(posedge core_clk) disable iff
    (!rstSync_reg) wordDone_reg && !isUdma);
  c_udma_toggle: cover property (@(posedge core_clk) disable iff
    (!rstSync_reg) $changed(strobe_reg) && isUdma);
  c_udma_resume: cover property (@(posedge core_clk) disable iff
    (!rstSync_reg) state_reg == ST_URUN && $past(state_reg) == ST_UPAUSE);

endmodule // ata_strobe_timing_generator

// *** dv/asg_drive_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Drive side: pause pin, changed just after the clock edge
// ************************************************************
module asg_drive_model (
  input wire logic core_clk,
  input wire logic pauseReq,
  input wire logic strobe,
  output logic pausePin,
  output int strobeEdges
);
  initial pausePin = 1'b0;
  always @(posedge core_clk) begin
    pausePin <= #1 pauseReq;
  end
  always @(strobe) begin
    strobeEdges = strobeEdges + 1;
  end
endmodule // asg_drive_model

// *** dv/ata_strobe_timing_generator_bench.sv ***
`timescale 1ns/1ps
module ata_strobe_timing_generator_bench;
  import asg_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  asg_timing_t timing = '0;
  logic wordReq = 1'b0;
  logic pauseReq = 1'b0;
  logic pausePin;
  logic strobe;
  logic wordDone;
  logic busy;
  int strobeEdges;
  int failures = 0;
  int n_compared = 0;
  int at[4] = '{12, 4, 4, 12};
  int rt[4] = '{14, 2, 1, 14};
  int ua[5] = '{5, 3, 2, 1, 5};
  int ur[5] = '{9, 7, 5, 5, 9};

  always #5 core_clk = ~core_clk;

  ata_strobe_timing_generator ata_strobe_timing_generator_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .timing(timing),
    .wordReq(wordReq),
    .pausePin(pausePin),
    .strobe(strobe),
    .wordDone(wordDone),
    .busy(busy)
  );

  asg_drive_model asg_drive_model_inst (
    .core_clk(core_clk),
    .pauseReq(pauseReq),
    .strobe(strobe),
    .pausePin(pausePin),
    .strobeEdges(strobeEdges)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_cnt(string name, int lo, int hi, int got);
    n_compared++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic check_bit(string name, logic expv, logic got);
    n_compared++;
    if (got !== expv) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", name, expv, got);
    end
  endtask

  task automatic count_run(output int n, output logic done);
    logic cur;
    cur = strobe;
    n = 0;
    do begin
      step();
      n++;
    end while (strobe === cur && n < 400);
    done = wordDone;
    if (n >= 400) begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      step();
      k++;
    end
    if (k >= 400) begin
      failures++;
      end_of_test();
    end
    check_bit("strobe idle", 1'b0, strobe);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic pio_run(asg_mode_t m, int a, int r);
    int n;
    logic d;
    timing = '{m, 8'(a), 8'(r)};
    wordReq = 1'b1;
    count_run(n, d);
    check_bit("busy run", 1'b1, busy);
    count_run(n, d);
    check_cnt("assert len", a + 1, a + 1, n);
    check_bit("done at fall", 1'b0, d);
    count_run(n, d);
    check_cnt("recover len", r + 2, r + 2, n);
    check_bit("done at rise", 1'b1, d);
    wordReq = 1'b0;
    wait_idle();
  endtask

  task automatic udma_run(int a, int r, bit doPause);
    int n;
    int ch;
    logic d;
    logic s;
    int e0;
    e0 = strobeEdges;
    timing = '{ASG_MODE_UDMA, 8'(a), 8'(r)};
    wordReq = 1'b1;
    count_run(n, d);
    repeat (2) begin
      count_run(n, d);
      check_cnt("udma half", a + 2, a + 2, n);
      check_bit("udma done", 1'b1, d);
    end
    if (doPause) begin
      pauseReq = 1'b1;
      s = strobe;
      ch = 0;
      repeat (20) begin
        step();
        if (strobe !== s || wordDone !== 1'b0) ch++;
      end
      check_cnt("pause frozen", 0, 0, ch);
      pauseReq = 1'b0;
      count_run(n, d);
      check_cnt("resume", r + a + 3, r + a + 8, n);
    end
    wordReq = 1'b0;
    step();
    timing.mode = ASG_MODE_PIO;
    wait_idle();
    check_cnt("strobe edges", 4, 4, strobeEdges - e0);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (3) step();
    check_bit("strobe in reset", 1'b0, strobe);
    check_bit("busy in reset", 1'b0, busy);
    rst_n = 1'b1;
    repeat (3) step();
    pio_run(ASG_MODE_PIO, 17, 16);
    pio_run(ASG_MODE_PIO, 1, 0);
    for (int i = 0; i < 4; i++) begin
      pio_run(ASG_MODE_MWDMA, at[i], rt[i]);
    end
    for (int i = 0; i < 5; i++) begin
      udma_run(ua[i], ur[i], i == 0);
    end
    end_of_test();
  end
endmodule // ata_strobe_timing_generator_bench
